//--- logic/adcctl_top.sv
// Digital control of a 16-bit sampling converter: conversion sequencing, busy, and result readout pins.
// Assumes all pin inputs are synchronous to clk_sys_in; the analog result arrives on conv_result_in.
//
// Overview of operation
// - A low serial/parallel select gives the parallel result bus, a high one turns shared pins into the serial port.
// - In serial mode the serial clock pin is an input or an output according to the clock source select.
// - In parallel mode the shared pin carries result bit eleven.
// - In serial mode with an external clock the shared bit eleven pin is the incomplete-read flag.
// - In serial slave mode a read still running when the next conversion ends loses its data and pulses the flag.
// - Result bits twelve to fifteen are outputs in either mode.
// - Busy rises when a conversion starts and falls once the result sits in the shift register.
// - The result output is enabled only while chip select and read are both low.
// - An external serial clock acts only while chip select is low.
// - A high reset input resets the block and aborts any conversion.
// - Power-down lets the current conversion finish, then blocks conversions and reduces power.
// - A start input high at the end of acquisition makes the block wait for its next falling edge to hold and convert.
// - A start input already low at the end of acquisition holds and converts at once.
// - The internal reference is on while its disable input is low and off while it is high.
// - The reference buffer is on while its disable input is low and off while it is high.
`default_nettype none
module adcctl_top #(
  parameter int RES_W = adcctl_pkg::RES_W
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic reset_in,
  input wire logic power_down_request_in,
  input wire logic convert_start_n_in,
  input wire logic serial_parallel_select_in,
  input wire logic serial_clock_source_select_in,
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic serial_clock_pin_in,
  input wire logic internal_ref_disable_in,
  input wire logic ref_buffer_disable_in,
  input wire logic [RES_W-1:0] conv_result_in,
  output logic busy_out,
  output logic sample_hold_out,
  output logic power_reduced_out,
  output logic ref_enable_out,
  output logic ref_buffer_enable_out,
  output logic incomplete_read_flag_out,
  output logic [RES_W-1:0] pin_out,
  output logic [RES_W-1:0] pin_oe_out
);
  adcctl_pkg::adcctl_state_t state;
  adcctl_pkg::adcctl_state_t next_state;
  logic [adcctl_pkg::TMR_W-1:0] timer;
  logic [adcctl_pkg::TMR_W-1:0] sclk_div;
  logic [adcctl_pkg::BITCNT_W-1:0] bit_cnt;
  logic [RES_W-1:0] result;
  logic [RES_W-1:0] next_pin;
  logic start_prev;
  logic sclk_gated_prev;
  logic sclk_int;
  logic unread;
  logic sdout;
  logic bus_en;
  logic serial_mode;
  logic slave_mode;
  logic start_fall;
  logic timer_zero;
  logic acq_end;
  logic conv_done;
  logic sclk_gated;
  logic slave_shift;
  logic master_run;
  logic master_tick;
  logic master_shift;
  logic shift;
  logic read_partial;

  function automatic logic out_enabled(input logic cs_n, input logic rd_n);
    out_enabled = !cs_n && !rd_n;
  endfunction

  assign bus_en = out_enabled(cs_n_in, rd_n_in);
  assign serial_mode = serial_parallel_select_in;
  assign slave_mode = serial_mode && serial_clock_source_select_in;
  assign start_fall = start_prev && !convert_start_n_in;
  assign timer_zero = (timer == adcctl_pkg::TMR_ZERO);
  assign acq_end = (state == adcctl_pkg::ADCCTL_ACQ) && timer_zero;
  assign conv_done = (state == adcctl_pkg::ADCCTL_CONV) && timer_zero;
  assign ref_enable_out = !internal_ref_disable_in;
  assign ref_buffer_enable_out = !ref_buffer_disable_in;
  assign power_reduced_out = (state == adcctl_pkg::ADCCTL_PD);
  assign sample_hold_out = (state == adcctl_pkg::ADCCTL_CONV);

  // The external clock is masked by chip select before edge detection, so stray edges never shift.
  assign sclk_gated = serial_clock_pin_in && !cs_n_in;
  assign slave_shift = slave_mode && bus_en && sclk_gated && !sclk_gated_prev
                       && (bit_cnt != adcctl_pkg::BITCNT_FULL);
  // The internal clock only runs for a finished, unread result, so a master read never overlaps busy.
  assign master_run = serial_mode && !serial_clock_source_select_in && bus_en && unread && !busy_out;
  assign master_tick = master_run && (sclk_div == adcctl_pkg::TMR_ZERO);
  assign master_shift = master_tick && !sclk_int;
  assign shift = slave_shift || master_shift;
  assign read_partial = (bit_cnt != adcctl_pkg::BITCNT_ZERO) && (bit_cnt != adcctl_pkg::BITCNT_FULL);

  always_comb begin
    next_state = state;
    case (state)
      adcctl_pkg::ADCCTL_ACQ: begin
        if (timer_zero) begin
          if (power_down_request_in) begin
            next_state = adcctl_pkg::ADCCTL_PD;
          end else if (!convert_start_n_in) begin
            next_state = adcctl_pkg::ADCCTL_CONV;
          end else begin
            next_state = adcctl_pkg::ADCCTL_WAIT;
          end
        end
      end
      adcctl_pkg::ADCCTL_WAIT: begin
        if (power_down_request_in) begin
          next_state = adcctl_pkg::ADCCTL_PD;
        end else if (start_fall) begin
          next_state = adcctl_pkg::ADCCTL_CONV;
        end
      end
      adcctl_pkg::ADCCTL_CONV: begin
        if (timer_zero) begin
          next_state = adcctl_pkg::ADCCTL_ACQ;
        end
      end
      adcctl_pkg::ADCCTL_PD: begin
        if (!power_down_request_in) begin
          next_state = adcctl_pkg::ADCCTL_ACQ;
        end
      end
      default: begin
        next_state = adcctl_pkg::ADCCTL_ACQ;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state <= adcctl_pkg::ADCCTL_ACQ;
    end else if (reset_in) begin
      state <= adcctl_pkg::ADCCTL_ACQ;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      timer <= adcctl_pkg::ACQ_LOAD;
    end else if (reset_in || (next_state == adcctl_pkg::ADCCTL_ACQ && state != adcctl_pkg::ADCCTL_ACQ)) begin
      timer <= adcctl_pkg::ACQ_LOAD;
    end else if (next_state == adcctl_pkg::ADCCTL_CONV && state != adcctl_pkg::ADCCTL_CONV) begin
      timer <= adcctl_pkg::CONV_LOAD;
    end else if (!timer_zero) begin
      timer <= timer - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_prev <= 1'b1;
      sclk_gated_prev <= 1'b0;
    end else begin
      start_prev <= convert_start_n_in;
      sclk_gated_prev <= sclk_gated;
    end
  end

  // Busy falls in the same cycle the result is latched into the shift register.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      busy_out <= 1'b0;
    end else if (reset_in || conv_done) begin
      busy_out <= 1'b0;
    end else if (next_state == adcctl_pkg::ADCCTL_CONV && state != adcctl_pkg::ADCCTL_CONV) begin
      busy_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result <= adcctl_pkg::RESULT_RST;
    end else if (conv_done && !reset_in) begin
      result <= conv_result_in;
    end
  end

  adcctl_shreg #(
    .W(RES_W)
  ) u_shreg (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .load_in(conv_done && !reset_in),
    .data_in(conv_result_in),
    .shift_in(shift),
    .msb_out(sdout)
  );

  // A new result restarts the bit count, which is how a partial slave read loses its data.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bit_cnt <= adcctl_pkg::BITCNT_ZERO;
    end else if (reset_in || conv_done) begin
      bit_cnt <= adcctl_pkg::BITCNT_ZERO;
    end else if (shift) begin
      bit_cnt <= bit_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      unread <= 1'b0;
    end else if (reset_in) begin
      unread <= 1'b0;
    end else if (conv_done) begin
      unread <= 1'b1;
    end else if (shift && bit_cnt == adcctl_pkg::BITCNT_FULL - 1'b1) begin
      unread <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_div <= adcctl_pkg::TMR_ZERO;
      sclk_int <= 1'b0;
    end else if (!master_run) begin
      sclk_div <= adcctl_pkg::SCLK_LOAD;
      sclk_int <= 1'b0;
    end else if (master_tick) begin
      sclk_div <= adcctl_pkg::SCLK_LOAD;
      sclk_int <= !sclk_int;
    end else begin
      sclk_div <= sclk_div - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      incomplete_read_flag_out <= 1'b0;
    end else begin
      incomplete_read_flag_out <= conv_done && !reset_in && slave_mode && read_partial;
    end
  end

  always_comb begin
    next_pin = result;
    if (serial_mode) begin
      next_pin[adcctl_pkg::PIN_SDOUT] = sdout;
      next_pin[adcctl_pkg::PIN_SCLK] = sclk_int;
      next_pin[adcctl_pkg::PIN_SYNC] = master_run;
      next_pin[adcctl_pkg::PIN_FLAG] = incomplete_read_flag_out;
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pin_out <= adcctl_pkg::RESULT_RST;
    end else begin
      pin_out <= next_pin;
    end
  end

  // Low pins serve only the parallel bus; in serial mode they float.
  always_comb begin
    pin_oe_out = '0;
    if (bus_en && !serial_mode) begin
      pin_oe_out = '1;
    end
    if (bus_en && serial_mode) begin
      pin_oe_out[adcctl_pkg::PIN_SDOUT] = 1'b1;
      pin_oe_out[adcctl_pkg::PIN_SCLK] = !serial_clock_source_select_in;
      pin_oe_out[adcctl_pkg::PIN_SYNC] = 1'b1;
    end
    if (slave_mode) begin
      pin_oe_out[adcctl_pkg::PIN_FLAG] = 1'b1;
    end
    pin_oe_out[adcctl_pkg::PIN_HI_HI:adcctl_pkg::PIN_HI_LO] = {4{bus_en}};
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  property p_busy_rise;
    !reset_in && state != adcctl_pkg::ADCCTL_CONV && next_state == adcctl_pkg::ADCCTL_CONV |=> busy_out;
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise at start");

  property p_busy_fall;
    busy_out && conv_done && !reset_in |=> !busy_out && unread;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy did not fall with the latch");

  property p_reset_abort;
    reset_in |=> !busy_out && state == adcctl_pkg::ADCCTL_ACQ;
  endproperty
  a_reset_abort: assert property (p_reset_abort) else $error("reset did not abort");

  property p_float;
    !bus_en |-> pin_oe_out[adcctl_pkg::PIN_SDOUT-1:0] == '0
                && pin_oe_out[adcctl_pkg::PIN_HI_HI:adcctl_pkg::PIN_HI_LO] == '0;
  endproperty
  a_float: assert property (p_float) else $error("result pins driven while disabled");

  property p_hi_out;
    bus_en |-> &pin_oe_out[adcctl_pkg::PIN_HI_HI:adcctl_pkg::PIN_HI_LO];
  endproperty
  a_hi_out: assert property (p_hi_out) else $error("upper result bits not driven");

  property p_bit11;
    // The pin register lags the result by one cycle, so compare with the result of the cycle before.
    bus_en && !serial_mode ##1 !serial_mode |-> pin_out[adcctl_pkg::PIN_FLAG] == $past(result[adcctl_pkg::PIN_FLAG]);
  endproperty
  a_bit11: assert property (p_bit11) else $error("bit eleven wrong in parallel mode");

  property p_flag_pulse;
    conv_done && !reset_in && slave_mode && read_partial |=> incomplete_read_flag_out ##1 !incomplete_read_flag_out;
  endproperty
  a_flag_pulse: assert property (p_flag_pulse) else $error("incomplete read not flagged");

  property p_pd_block;
    state == adcctl_pkg::ADCCTL_PD && power_down_request_in && !reset_in |=> !busy_out && power_reduced_out;
  endproperty
  a_pd_block: assert property (p_pd_block) else $error("conversion during power down");

  property p_immediate;
    acq_end && !reset_in && !power_down_request_in && !convert_start_n_in |=> busy_out && sample_hold_out;
  endproperty
  a_immediate: assert property (p_immediate) else $error("no immediate conversion");

  property p_wait_edge;
    state == adcctl_pkg::ADCCTL_WAIT && !start_fall |=> !busy_out;
  endproperty
  a_wait_edge: assert property (p_wait_edge) else $error("converted without a falling edge");

  property p_gate_clk;
    slave_shift |-> !cs_n_in && $past(!sclk_gated);
  endproperty
  a_gate_clk: assert property (p_gate_clk) else $error("external clock shifted without chip select");
endmodule
`default_nettype wire

//--- inc/adcctl_pkg.sv
// Shared constants for the converter control block: timing, widths and shared pin positions.
// Assumes a single 20 MHz system clock; the acquisition and conversion times below derive cycle counts from it.
`default_nettype none
package adcctl_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  // Acquisition is a least time, so it rounds up; conversion is a longest time, so it rounds down.
  localparam int T_ACQ_NS = 1000;
  localparam int T_CONV_NS = 8000;
  localparam int ACQ_CYC = (T_ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC = (T_CONV_NS / CLK_PERIOD_NS) < 1 ? 1 : (T_CONV_NS / CLK_PERIOD_NS);
  // Half period of the internally generated serial clock, in system cycles.
  localparam int SCLK_HALF_CYC = 2;
  localparam int RES_W = 16;
  localparam int TMR_W = 16;
  localparam int BITCNT_W = 5;
  localparam int PIN_SDOUT = 8;
  localparam int PIN_SCLK = 9;
  localparam int PIN_SYNC = 10;
  localparam int PIN_FLAG = 11;
  localparam int PIN_HI_LO = 12;
  localparam int PIN_HI_HI = 15;
  localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_ZERO = 16'h0000;
  localparam logic [BITCNT_W-1:0] BITCNT_ZERO = 5'h00;
  localparam logic [BITCNT_W-1:0] BITCNT_FULL = 5'h10;
  localparam logic [TMR_W-1:0] ACQ_LOAD = TMR_W'(ACQ_CYC - 1);
  localparam logic [TMR_W-1:0] CONV_LOAD = TMR_W'(CONV_CYC - 1);
  localparam logic [TMR_W-1:0] SCLK_LOAD = TMR_W'(SCLK_HALF_CYC - 1);

  typedef enum logic [1:0] {
    ADCCTL_ACQ  = 2'b00,
    ADCCTL_WAIT = 2'b01,
    ADCCTL_CONV = 2'b10,
    ADCCTL_PD   = 2'b11
  } adcctl_state_t;
endpackage
`default_nettype wire

//--- logic/adcctl_shreg.sv
// Output shift register holding the latched conversion result, MSB first.
// Assumes load and shift are one-cycle strobes in the system clock domain.
`default_nettype none
module adcctl_shreg #(
  parameter int W = 16
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic load_in,
  input wire logic [W-1:0] data_in,
  input wire logic shift_in,
  output logic msb_out
);
  logic [W-1:0] sreg;

  // Load wins over shift so a fresh result is never shifted on its first cycle.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sreg <= '0;
    end else if (load_in) begin
      sreg <= data_in;
    end else if (shift_in) begin
      sreg <= {sreg[W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      msb_out <= 1'b0;
    end else if (load_in) begin
      msb_out <= data_in[W-1];
    end else if (shift_in) begin
      msb_out <= sreg[W-2];
    end
  end
endmodule
`default_nettype wire

//--- tb/adcctl_host.sv
// Host model: reads results with chip select, read strobe and an external serial clock.
// Assumes the bench commands it and that it shares the block's system clock.
`default_nettype none
module adcctl_host (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic read_req_in,
  input wire logic stray_clk_in,
  input wire logic [4:0] nbits_in,
  input wire logic sdata_in,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic sclk_out,
  output logic [15:0] word_out,
  output logic done_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph;
  logic [4:0] cnt;
  assign done_out = (cnt == nbits_in) && !cs_n_out;
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cs_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      sclk_out <= 1'b0;
      cnt <= 5'h00;
      ph <= 3'h0;
      word_out <= 16'h0000;
    end else if (!read_req_in) begin
      cs_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      cnt <= 5'h00;
      ph <= 3'h0;
      // Stray edges with chip select high are a deliberate test of the clock gate.
      sclk_out <= stray_clk_in ? ~sclk_out : 1'b0;
    end else begin
      cs_n_out <= 1'b0;
      rd_n_out <= 1'b0;
      if (cnt != nbits_in) begin
        ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
        // Three cycles per clock phase leaves the registered data pin settled before each sample.
        if (ph == 3'h2) begin
          word_out <= {word_out[14:0], sdata_in};
          sclk_out <= 1'b1;
        end
        if (ph == 3'h5) begin
          sclk_out <= 1'b0;
          cnt <= cnt + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/adcctl_top_bench.sv
// Self-checking bench for the converter control block with a host model on its read side.
// Assumes the host model file is compiled first and the package is visible.
`default_nettype none
module adcctl_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, nrst = 1'b0, rst_cv = 1'b0, pd = 1'b0, start_n = 1'b1, ser = 1'b0, ext = 1'b0;
  logic ird = 1'b0, ibd = 1'b0, req = 1'b0, stray = 1'b0;
  logic [4:0] nbits = 5'h00;
  logic [15:0] res = 16'h0000;
  logic busy, sh, pred, ren, rben, flag, cs_n, rd_n, sclk, done;
  logic [15:0] pin, oe, word;
  int error_cnt = 0, checks = 0;
  localparam int CONV = adcctl_pkg::CONV_CYC;
  adcctl_top u_dut (.clk_sys_in(clk), .nrst_in(nrst), .reset_in(rst_cv), .power_down_request_in(pd),
    .convert_start_n_in(start_n), .serial_parallel_select_in(ser), .serial_clock_source_select_in(ext),
    .cs_n_in(cs_n), .rd_n_in(rd_n), .serial_clock_pin_in(sclk), .internal_ref_disable_in(ird),
    .ref_buffer_disable_in(ibd), .conv_result_in(res), .busy_out(busy), .sample_hold_out(sh),
    .power_reduced_out(pred), .ref_enable_out(ren), .ref_buffer_enable_out(rben),
    .incomplete_read_flag_out(flag), .pin_out(pin), .pin_oe_out(oe));
  adcctl_host u_host (.clk_sys_in(clk), .nrst_in(nrst), .read_req_in(req), .stray_clk_in(stray),
    .nbits_in(nbits), .sdata_in(pin[8]), .cs_n_out(cs_n), .rd_n_out(rd_n), .sclk_out(sclk),
    .word_out(word), .done_out(done));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 400) begin
      @(negedge clk);
      n++;
    end
    check("busy level", 16'(busy), 16'(v));
  endtask
  task automatic busy_len(output int n);
    n = 0;
    while (busy === 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic host_read(input logic [4:0] n);
    int k;
    @(posedge clk);
    nbits <= n;
    req <= 1'b1;
    @(negedge clk);
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    check("read done", 16'(done), 16'h0001);
  endtask
  task automatic drop_read;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic start_conv(input logic [15:0] v);
    @(posedge clk);
    res <= v;
    start_n <= 1'b0;
    wait_busy(1'b1);
    @(posedge clk);
    start_n <= 1'b1;
  endtask
  task automatic t_refs;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      ird <= i[0];
      ibd <= i[1];
      @(negedge clk);
      check("ref on", 16'(ren), 16'(!i[0]));
      check("buffer on", 16'(rben), 16'(!i[1]));
    end
    check("idle oe", oe, 16'h0000);
    $display("test refs done");
  endtask
  task automatic t_start_edge;
    int n;
    repeat (40) @(negedge clk);
    check("no start", 16'(busy), 16'h0000);
    @(posedge clk);
    res <= 16'hA5C3;
    start_n <= 1'b0;
    repeat (3) @(negedge clk);
    check("busy on fall", 16'(busy), 16'h0001);
    check("hold", 16'(sh), 16'h0001);
    busy_len(n);
    check("busy length", 16'(n), 16'(CONV - 1));
    check("track", 16'(sh), 16'h0000);
    @(posedge clk);
    start_n <= 1'b1;
    $display("test start edge done");
  endtask
  task automatic t_parallel;
    host_read(5'h00);
    check("par oe", oe, 16'hFFFF);
    check("par data", pin, 16'hA5C3);
    drop_read();
    check("par float", oe, 16'h0000);
    $display("test parallel done");
  endtask
  task automatic t_start_low;
    int n;
    @(posedge clk);
    res <= 16'h3C96;
    start_n <= 1'b0;
    wait_busy(1'b1);
    busy_len(n);
    n = 0;
    while (busy !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check("acq length", 16'(n), 16'(adcctl_pkg::ACQ_CYC));
    @(posedge clk);
    start_n <= 1'b1;
    wait_busy(1'b0);
    $display("test start low done");
  endtask
  task automatic t_serial;
    @(posedge clk);
    ser <= 1'b1;
    ext <= 1'b1;
    stray <= 1'b1;
    repeat (10) @(posedge clk);
    stray <= 1'b0;
    repeat (2) @(posedge clk);
    host_read(5'h10);
    check("ser oe", oe, 16'hFD00);
    check("ser word", word, 16'h3C96);
    drop_read();
    check("flag pin oe", oe, 16'h0800);
    $display("test serial done");
  endtask
  task automatic t_overrun;
    int fl, pf;
    start_conv(16'h1234);
    wait_busy(1'b0);
    host_read(5'h05);
    start_conv(16'h5678);
    fl = 0;
    pf = 0;
    repeat (200) begin
      @(negedge clk);
      fl += int'(flag);
      pf += int'(pin[11]);
    end
    check("flag pulses", 16'(fl), 16'h0001);
    check("flag pin pulses", 16'(pf), 16'h0001);
    drop_read();
    host_read(5'h10);
    check("new word", word, 16'h5678);
    drop_read();
    $display("test overrun done");
  endtask
  task automatic t_abort;
    int n;
    start_conv(16'h0F0F);
    repeat (50) @(posedge clk);
    rst_cv <= 1'b1;
    @(posedge clk);
    rst_cv <= 1'b0;
    @(negedge clk);
    check("abort", 16'(busy), 16'h0000);
    n = 0;
    repeat (170) begin
      @(negedge clk);
      n += int'(busy);
    end
    check("stays idle", 16'(n), 16'h0000);
    $display("test abort done");
  endtask
  task automatic t_power_down;
    int n;
    @(posedge clk);
    start_n <= 1'b0;
    wait_busy(1'b1);
    @(posedge clk);
    pd <= 1'b1;
    @(negedge clk);
    busy_len(n);
    check("finish conv", 16'(n), 16'(CONV - 1));
    repeat (300) begin
      @(negedge clk);
      n += int'(busy);
    end
    check("blocked", 16'(n), 16'(CONV - 1));
    check("low power", 16'(pred), 16'h0001);
    @(posedge clk);
    pd <= 1'b0;
    wait_busy(1'b1);
    @(posedge clk);
    start_n <= 1'b1;
    wait_busy(1'b0);
    $display("test power down done");
  endtask
  // The internal clock runs on its own once selected, so the bench samples the data pin before each rise.
  task automatic t_master;
    logic l8, l9;
    int r, s;
    logic [15:0] w;
    @(posedge clk);
    ext <= 1'b0;
    nbits <= 5'h00;
    req <= 1'b1;
    l8 = 1'b0;
    l9 = 1'b0;
    r = 0;
    s = 0;
    w = 16'h0000;
    repeat (3) @(negedge clk);
    check("master oe", oe, 16'hF700);
    repeat (120) begin
      @(negedge clk);
      if (pin[9] && !l9) begin
        w = {w[14:0], l8};
        r++;
      end
      s += int'(pin[10]);
      l8 = pin[8];
      l9 = pin[9];
    end
    check("master word", w, 16'h0F0F);
    check("master edges", 16'(r), 16'h0010);
    check("sync seen", 16'(s != 0), 16'h0001);
    check("sync stops", 16'(pin[10]), 16'h0000);
    drop_read();
    $display("test master done");
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_refs();
    t_start_edge();
    t_parallel();
    t_start_low();
    t_serial();
    t_overrun();
    t_abort();
    t_power_down();
    t_master();
    give_verdict();
  end
endmodule
`default_nettype wire
